/* rtl/dwfl_top.sv */
// Dual watchdog supervisor with clear-on-read fault log and register port
`timescale 1ns/1ps
module dwfl_top import dwfl_pkg::*; #(
  parameter logic [CNT_W-1:0] BASE_CYCLES = CNT_W'(BASE_PERIOD_CYCLES)
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  // Register port behind the serial interface
  input  wire logic [REG_W-1:0]   reg_addr,
  input  wire logic [REG_W-1:0]   reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [REG_W-1:0]   reg_rdata,
  output logic                    reg_ack,
  output logic                    reg_err,
  // Supervised signals
  input  wire logic [NUM_GI-1:0]  general_input,
  input  wire logic [NUM_PO-1:0]  programmable_output,
  input  wire logic               manual_reset_input_n,
  input  wire logic [NUM_VIN-1:0] primary_threshold_fault_in,
  input  wire logic [NUM_VIN-1:0] secondary_threshold_fault_in,
  // Watchdog results
  output logic      [NUM_WD-1:0]  watchdog_timeout,
  output logic      [NUM_WD-1:0]  watchdog_fault
);

  // ---------------------------------------------------------------
  // Decode helper
  // ---------------------------------------------------------------
  // Address match, shared by every register decode
  function automatic logic addr_is(
    input logic [REG_W-1:0] a,
    input logic [REG_W-1:0] ref_a
  );
    addr_is = (a == ref_a);
  endfunction

  localparam int NUM_RD = NUM_WD + NUM_FLT;  // Readable register groups

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [NUM_WD-1:0][REG_W-1:0]  sel_ff, nxt_sel;   // Input select registers
  logic [NUM_WD-1:0][REG_W-1:0]  per_ff, nxt_per;   // Period and enable registers
  logic [NUM_GI-1:0]             gi_prev_ff;        // General inputs last cycle
  logic [NUM_PO-1:0]             po_prev_ff;        // Outputs last cycle
  logic                          mr_prev_ff;        // Manual reset last cycle
  logic [REG_W-1:0]              rdata_ff;          // Read data
  logic                          ack_ff, err_ff;    // Answer flags
  logic [NUM_WD-1:0]             wd_to;             // Timeout pulses
  logic [NUM_WD-1:0]             wd_flt;            // Fault levels
  logic [NUM_WD-1:0]             sel_wr, per_wr;    // Write strobes
  logic [NUM_WD-1:0]             wd_hit;            // Watchdog address hit
  logic [NUM_FLT-1:0]            flt_hit;           // Fault address hit
  logic [NUM_WD:0][NUM_GI-1:0]   gi_acc;            // Input fault fold
  logic [NUM_RD:0][REG_W-1:0]    rd_acc;            // Read data fold
  logic [NUM_FLT-1:0][REG_W-1:0] flt_set;           // Fault events
  logic [NUM_FLT-1:0][REG_W-1:0] flt_flags;         // Stored faults

  // ---------------------------------------------------------------
  // Activity detection
  // ---------------------------------------------------------------
  // Inputs are synchronous, so a plain compare finds every toggle
  wire [NUM_GI-1:0] gi_chg    = general_input ^ gi_prev_ff;
  wire [NUM_PO-1:0] po_chg    = programmable_output ^ po_prev_ff;
  wire              mr_active = !manual_reset_input_n;
  // Reset event restarts every enabled watchdog, in its initial period only where that is enabled
  wire              mr_rise   = mr_active && !mr_prev_ff;

  // Previous-value registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gi_prev_ff <= '0;
      po_prev_ff <= '0;
      mr_prev_ff <= 1'b0;
    end else begin
      gi_prev_ff <= general_input;
      po_prev_ff <= programmable_output;
      mr_prev_ff <= mr_active;
    end
  end

  // ---------------------------------------------------------------
  // Watchdogs and their configuration
  // ---------------------------------------------------------------
  assign gi_acc[0] = '0;

  for (genvar g = 0; g < NUM_WD; g++) begin : g_wd
    wire [GI_W-1:0]  gi_sel  = sel_ff[g][GI_LSB +: GI_W];
    wire [PO_W-1:0]  po_sel  = sel_ff[g][PO_LSB +: PO_W];
    wire [DEP_W-1:0] dep     = sel_ff[g][DEP_LSB +: DEP_W];
    wire             uses_gi = (dep != DEP_PO_ONLY);

    // Own register pair per watchdog
    assign sel_wr[g]  = reg_wr && addr_is(reg_addr, WD_SEL_ADDR[g]);
    assign per_wr[g]  = reg_wr && addr_is(reg_addr, WD_PER_ADDR[g]);
    assign wd_hit[g]  = addr_is(reg_addr, WD_SEL_ADDR[g]) || addr_is(reg_addr, WD_PER_ADDR[g]);
    assign nxt_sel[g] = sel_wr[g] ? reg_wdata : sel_ff[g];
    // Unused top bit never stored, so it reads zero
    assign nxt_per[g] = per_wr[g] ? (reg_wdata & PER_MASK) : per_ff[g];

    // Timed-out watchdog also flags the general input it watches
    assign gi_acc[g+1] = gi_acc[g] |
                         ((wd_to[g] && uses_gi) ? dwfl_onehot_gi(gi_sel) : '0);

    // Read term for this register pair
    assign rd_acc[g+1] = rd_acc[g] |
      (addr_is(reg_addr, WD_SEL_ADDR[g]) ? sel_ff[g] : '0) |
      (addr_is(reg_addr, WD_PER_ADDR[g]) ? per_ff[g] : '0);

    dwfl_watchdog #(
      .BASE_CYCLES (BASE_CYCLES)
    ) u_wd (
      .ref_clk     (ref_clk),
      .reset_n     (reset_n),
      .enable      (per_ff[g][WD_EN_BIT]),
      .init_enable (sel_ff[g][INIT_EN_BIT]),
      .dep         (dep),
      .init_code   (per_ff[g][INIT_LSB +: PER_W]),
      .norm_code   (per_ff[g][NORM_LSB +: PER_W]),
      .gi_edge     (gi_chg[gi_sel]),
      .po_edge     (po_chg[po_sel]),
      .reset_event (mr_rise),
      .timeout     (wd_to[g]),
      .fault       (wd_flt[g])
    );
  end

  assign watchdog_timeout = wd_to;
  assign watchdog_fault   = wd_flt;

  // Configuration registers; cleared so watchdogs start disabled
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_ff <= {NUM_WD{SEL_RST}};
      per_ff <= {NUM_WD{PER_RST}};
    end else begin
      sel_ff <= nxt_sel;
      per_ff <= nxt_per;
    end
  end

  // ---------------------------------------------------------------
  // Fault log
  // ---------------------------------------------------------------
  // Voltage faults are levels; flag rises again while still low
  assign flt_set[FLT_PRI] = REG_W'(primary_threshold_fault_in) & VOLT_MASK;
  assign flt_set[FLT_SEC] = REG_W'(secondary_threshold_fault_in) & VOLT_MASK;
  // Watchdog, input and manual reset events share one register
  assign flt_set[FLT_EVT] = ((REG_W'(wd_to) << EVT_WD_LSB) |
                             (REG_W'(gi_acc[NUM_WD]) << EVT_GI_LSB) |
                             (REG_W'(mr_active) << EVT_MR_BIT)) & EVT_MASK;

  for (genvar f = 0; f < NUM_FLT; f++) begin : g_flt
    assign flt_hit[f]          = addr_is(reg_addr, FLT_ADDR[f]);
    assign rd_acc[NUM_WD+f+1]  = rd_acc[NUM_WD+f] | (flt_hit[f] ? flt_flags[f] : '0);
  end

  // Any fault read clears every flag in the same edge that captures data
  wire flt_clear = reg_rd && (|flt_hit);

  dwfl_fault_log u_log (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .flag_set   (flt_set),
    .flag_clear (flt_clear),
    .flags      (flt_flags)
  );

  // ---------------------------------------------------------------
  // Register port answer
  // ---------------------------------------------------------------
  assign rd_acc[0] = '0;
  wire rd_hit  = (|wd_hit) || (|flt_hit);
  // Fault registers take no writes; such a write is refused
  wire wr_hit  = |wd_hit;
  wire bad_req = (reg_rd && !rd_hit) || (reg_wr && !wr_hit);

  // Answer one cycle after the request; unmapped reads return zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= '0;
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
    end else begin
      rdata_ff <= reg_rd ? rd_acc[NUM_RD] : rdata_ff;
      ack_ff   <= reg_rd || reg_wr;
      err_ff   <= bad_req;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_ack   = ack_ff;
  assign reg_err   = err_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sel_write_a : assert property (sel_wr[0] |=> sel_ff[0] == $past(reg_wdata))
    else $error("input select write lost");
  per_bit7_a : assert property (per_wr[1] |=> per_ff[1] == ($past(reg_wdata) & PER_MASK))
    else $error("period register stores unused bit");
  read_data_a : assert property (reg_rd && flt_hit[FLT_PRI] |=>
    reg_ack && reg_rdata == $past(flt_flags[FLT_PRI]))
    else $error("fault read data wrong");
  read_clear_a : assert property (flt_clear |=> flt_flags == $past(flt_set))
    else $error("fault read did not clear flags");
  mr_log_a : assert property (mr_active |=> flt_flags[FLT_EVT][EVT_MR_BIT])
    else $error("manual reset not logged");
  wd_log_a : assert property (wd_to[0] |=> flt_flags[FLT_EVT][EVT_WD_LSB])
    else $error("watchdog timeout not logged");
  gi_log_a : assert property (wd_to[1] && (sel_ff[1][DEP_LSB +: DEP_W] != DEP_PO_ONLY)
    |=> flt_flags[FLT_EVT][EVT_GI_LSB + $past(sel_ff[1][GI_LSB +: GI_W])])
    else $error("watched input fault not logged");
  pri_bits_a : assert property (primary_threshold_fault_in[0] |=>
    flt_flags[FLT_PRI][0] && (flt_flags[FLT_PRI] & ~VOLT_MASK) == '0)
    else $error("primary fault bit wrong");
  bad_addr_a : assert property (reg_rd && !rd_hit |=> reg_err && reg_rdata == '0)
    else $error("unmapped read not refused");

  wd_timeout_c : cover property (wd_to[0] ##[1:20] flt_clear);
  both_wd_c    : cover property (wd_flt[0] && wd_flt[1]);
  mr_clear_c   : cover property (mr_active && flt_clear);

endmodule

/* rtl/dwfl_pkg.sv */
// Shared constants, types and helpers for the dual watchdog and fault log
package dwfl_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int REG_W   = 8;   // Register width
  localparam int NUM_WD  = 2;   // Independent watchdogs
  localparam int NUM_GI  = 4;   // General inputs
  localparam int NUM_PO  = 8;   // Programmable outputs
  localparam int NUM_VIN = 6;   // Monitored voltage inputs
  localparam int NUM_FLT = 3;   // Fault registers
  localparam int CNT_W   = 32;  // Interval counter width

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] WD_SEL_ADDR [NUM_WD]  = '{8'h3c, 8'h3e};
  localparam logic [REG_W-1:0] WD_PER_ADDR [NUM_WD]  = '{8'h3d, 8'h3f};
  localparam logic [REG_W-1:0] FLT_ADDR    [NUM_FLT] = '{8'h60, 8'h61, 8'h62};
  localparam int FLT_PRI = 0;  // Primary threshold faults
  localparam int FLT_SEC = 1;  // Secondary threshold faults
  localparam int FLT_EVT = 2;  // Watchdog, input and manual reset faults

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  localparam int GI_LSB      = 0;  // Input select: general input
  localparam int GI_W        = 2;
  localparam int PO_LSB      = 2;  // Input select: programmable output
  localparam int PO_W        = 3;
  localparam int DEP_LSB     = 5;  // Input select: dependency
  localparam int DEP_W       = 2;
  localparam int INIT_EN_BIT = 7;  // Input select: initial period enable
  localparam int NORM_LSB    = 0;  // Period: normal code
  localparam int INIT_LSB    = 3;  // Period: initial code
  localparam int PER_W       = 3;
  localparam int WD_EN_BIT   = 6;  // Period: watchdog enable
  localparam int EVT_WD_LSB  = 0;  // Event faults: watchdog bits
  localparam int EVT_GI_LSB  = 2;  // Event faults: general input bits
  localparam int EVT_MR_BIT  = 6;  // Event faults: manual reset bit
  localparam logic [REG_W-1:0] PER_MASK  = 8'h7f;
  localparam logic [REG_W-1:0] VOLT_MASK = 8'h3f;
  localparam logic [REG_W-1:0] EVT_MASK  = 8'h7f;
  localparam logic [REG_W-1:0] SEL_RST   = 8'h00;
  localparam logic [REG_W-1:0] PER_RST   = 8'h00;
  localparam logic [REG_W-1:0] FLT_RST   = 8'h00;

  // Dependency codes
  localparam logic [DEP_W-1:0] DEP_BOTH_A  = 2'h0;
  localparam logic [DEP_W-1:0] DEP_PO_ONLY = 2'h1;
  localparam logic [DEP_W-1:0] DEP_GI_ONLY = 2'h2;
  localparam logic [DEP_W-1:0] DEP_BOTH_B  = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam real CLK_PERIOD_NS  = 100.0;  // 10 MHz reference
  localparam real NS_PER_MS      = 1.0e6;
  localparam real BASE_PERIOD_MS = 6.25;   // Shortest timeout
  localparam int  BASE_PERIOD_CYCLES =
    int'($floor(BASE_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS));
  localparam int  STEP_SHIFT     = 2;      // Each code step is four times longer

  typedef enum logic [1:0] {WDS_OFF, WDS_INIT, WDS_NORMAL} dwfl_wd_state_e;

  // Cycles in one interval for a period code
  function automatic logic [CNT_W-1:0] dwfl_period_cycles(
    input logic [PER_W-1:0] code,
    input logic [CNT_W-1:0] base
  );
    dwfl_period_cycles = base << (STEP_SHIFT * code);
  endfunction

  // One-hot flag for a general input code
  function automatic logic [NUM_GI-1:0] dwfl_onehot_gi(input logic [GI_W-1:0] sel);
    dwfl_onehot_gi = {{(NUM_GI-1){1'b0}}, 1'b1} << sel;
  endfunction

endpackage

/* rtl/dwfl_fault_log.sv */
// Sticky clear-on-read fault flag storage
`timescale 1ns/1ps
module dwfl_fault_log import dwfl_pkg::*; (
  // Clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            reset_n,
  // Events and clear
  input  wire logic [NUM_FLT-1:0][REG_W-1:0]   flag_set,
  input  wire logic                            flag_clear,
  // Stored flags
  output logic      [NUM_FLT-1:0][REG_W-1:0]   flags
);

  // ---------------------------------------------------------------
  // Flag storage
  // ---------------------------------------------------------------
  logic [NUM_FLT-1:0][REG_W-1:0] flags_ff;   // Volatile, lost at reset
  logic [NUM_FLT-1:0][REG_W-1:0] nxt_flags;  // Next flag value

  // Set wins over clear so an event in the read cycle survives
  assign nxt_flags = (flags_ff & ~{(NUM_FLT*REG_W){flag_clear}}) | flag_set;
  assign flags     = flags_ff;

  // Flag register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= {NUM_FLT{FLT_RST}};
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  set_wins_a : assert property ((flag_set != '0) |=>
    ((flags_ff & $past(flag_set)) == $past(flag_set)))
    else $error("fault event lost");

endmodule

/* rtl/dwfl_watchdog.sv */
// One watchdog timer with initial and normal intervals
`timescale 1ns/1ps
module dwfl_watchdog import dwfl_pkg::*; #(
  parameter logic [CNT_W-1:0] BASE_CYCLES = CNT_W'(BASE_PERIOD_CYCLES)
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Configuration
  input  wire logic             enable,
  input  wire logic             init_enable,
  input  wire logic [DEP_W-1:0] dep,
  input  wire logic [PER_W-1:0] init_code,
  input  wire logic [PER_W-1:0] norm_code,
  // Activity
  input  wire logic             gi_edge,
  input  wire logic             po_edge,
  input  wire logic             reset_event,
  // Results
  output logic                  timeout,
  output logic                  fault
);

  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dwfl_wd_state_e   state_ff, nxt_state;  // Interval phase
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;      // Cycles into interval
  logic             en_prev_ff;           // Enable last cycle
  logic             gi_seen_ff, po_seen_ff; // Source toggled this interval
  logic             timeout_ff, fault_ff;

  // ---------------------------------------------------------------
  // Clearing and expiry
  // ---------------------------------------------------------------
  wire need_gi  = (dep != DEP_PO_ONLY);
  wire need_po  = (dep != DEP_GI_ONLY);
  wire running  = enable && (state_ff != WDS_OFF);
  wire start    = enable && (!en_prev_ff || reset_event);
  wire relevant = (need_gi && gi_edge) || (need_po && po_edge);
  wire gi_ok    = !need_gi || gi_seen_ff || gi_edge;
  wire po_ok    = !need_po || po_seen_ff || po_edge;
  // Every source that the dependency code needs must have toggled inside one interval
  wire kick     = running && !start && relevant && gi_ok && po_ok;
  wire [PER_W-1:0] act_code = (state_ff == WDS_INIT) ? init_code : norm_code;
  wire [CNT_W-1:0] limit    = dwfl_period_cycles(act_code, BASE_CYCLES);
  wire expire   = running && !start && !kick && (cnt_ff == limit - CNT_ONE);
  wire restart  = start || kick || expire;

  // Initial period only when enabled for it, then normal until the next start
  assign nxt_state = !enable ? WDS_OFF :
                     start ? (init_enable ? WDS_INIT : WDS_NORMAL) :
                     (kick || expire) ? WDS_NORMAL : state_ff;
  assign nxt_cnt   = (!running || restart) ? '0 : cnt_ff + CNT_ONE;
  assign timeout   = timeout_ff;
  assign fault     = fault_ff;

  // Phase and counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= WDS_OFF;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Toggle memory, pulse and fault level; clearing wins over expiry
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_prev_ff <= 1'b0;
      gi_seen_ff <= 1'b0;
      po_seen_ff <= 1'b0;
      timeout_ff <= 1'b0;
      fault_ff   <= 1'b0;
    end else begin
      en_prev_ff <= enable;
      gi_seen_ff <= (!running || restart) ? 1'b0 : (gi_seen_ff || gi_edge);
      po_seen_ff <= (!running || restart) ? 1'b0 : (po_seen_ff || po_edge);
      timeout_ff <= expire;
      fault_ff   <= expire ? 1'b1 : ((kick || start || !enable) ? 1'b0 : fault_ff);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  expire_time_a : assert property ($rose(timeout_ff) |->
    ($past(cnt_ff) == $past(limit) - CNT_ONE))
    else $error("timeout at wrong count");
  off_quiet_a : assert property (!enable |=> !timeout_ff && !fault_ff)
    else $error("disabled watchdog reports fault");
  init_phase_a : assert property (start && init_enable |=> state_ff == WDS_INIT)
    else $error("initial period not entered");
  normal_after_a : assert property (timeout_ff |-> state_ff == WDS_NORMAL)
    else $error("not normal after interval");
  po_ignored_a : assert property (
    running && (dep == DEP_GI_ONLY) && !gi_edge && !start && !expire && enable
    |=> cnt_ff == $past(cnt_ff) + CNT_ONE)
    else $error("output edge cleared input-only watchdog");
  gi_ignored_a : assert property (
    running && (dep == DEP_PO_ONLY) && !po_edge && !start && !expire && enable
    |=> cnt_ff == $past(cnt_ff) + CNT_ONE)
    else $error("input edge cleared output-only watchdog");
  kick_clear_a : assert property (kick |=> cnt_ff == '0 && !fault_ff)
    else $error("clearing did not restart interval");

  init_timeout_c : cover property (state_ff == WDS_INIT ##1 timeout_ff);
  both_kick_c    : cover property (need_gi && need_po && kick);

endmodule

/* tb/dwfl_cpu_model.sv */
// Supervised processor model that kicks a watchdog input
`timescale 1ns/1ps
module dwfl_cpu_model (
  // Clock and control
  input  wire logic ref_clk,
  input  wire logic run,
  // Kick line
  output logic      kick
);
  logic [1:0] cnt_ff = 2'h0;  // Kick spacing
  initial kick = 1'b0;
  // --------
  // Kick
  // --------
  // Toggle every fourth cycle, half the shortest period
  always @(negedge ref_clk) begin
    cnt_ff <= cnt_ff + 2'h1;
    if (run && cnt_ff == 2'h3) kick <= !kick;
  end
endmodule

/* tb/dwfl_top_tb.sv */
// Self-checking bench for the dual watchdog and fault log
`timescale 1ns/1ps
module dwfl_top_tb;
  logic       ref_clk, reset_n, reg_wr, reg_rd, reg_ack, reg_err, mr_n, run, kick;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, po;
  logic [2:0] gi_hi;
  logic [5:0] pri, sec;
  logic [1:0] wd_to, wd_f;
  int         n_errors = 0, num_checks = 0, cyc = 0;
  bit         skip_rd = 1'b0;  // Host throws this read's data away
  // Short base count keeps the periods of small codes a few cycles long
  dwfl_top #(.BASE_CYCLES(32'h8)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
    .general_input({gi_hi, kick}), .programmable_output(po),
    .manual_reset_input_n(mr_n), .primary_threshold_fault_in(pri),
    .secondary_threshold_fault_in(sec), .watchdog_timeout(wd_to),
    .watchdog_fault(wd_f));
  dwfl_cpu_model cpu (.ref_clk(ref_clk), .run(run), .kick(kick));
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim;
    end
  end
  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // One register access, request held across one rising edge
  task automatic xfer(input logic w, input logic [7:0] a, d, e, input logic ee);
    @(negedge ref_clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 0;
    reg_rd = 0;
    for (int i = 0; i < 3 && reg_ack !== 1'b1; i++) @(negedge ref_clk);
    chk("ack", 1, {7'h0, reg_ack});
    chk("err", {7'h0, ee}, {7'h0, reg_err});
    if (!w && !skip_rd) chk("rdata", e, reg_rdata);
  endtask
  // Wait for a timeout pulse; the fault level rises with it
  task automatic wfault(input int b);
    repeat (40) if (wd_to[b] !== 1'b1) @(negedge ref_clk);
    chk("wd_timeout", 1, {7'h0, wd_to[b]});
    chk("wd_fault", 1, {7'h0, wd_f[b]});
  endtask
  // Cycles from the call to the next timeout pulse
  task automatic wtime(input int b, input int n_exp);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (wd_to[b] !== 1'b1 && n < 200);
    chk("wd_period", 8'(n_exp), 8'(n));
  endtask
  // Fifteen toggles of one output, four cycles apart
  task automatic tog_po(input int k);
    repeat (15) begin
      repeat (4) @(negedge ref_clk);
      po[k] = !po[k];
    end
  endtask
  initial begin
    {reg_wr, reg_rd, run, reset_n} = 0;
    {reg_addr, reg_wdata, po, gi_hi, pri, sec} = 0;
    mr_n = 1;
    repeat (20) @(negedge ref_clk);
    reset_n = 1;
    for (int a = 8'h3c; a < 8'h40; a++) xfer(0, 8'(a), 0, 0, 0);
    // First fault read after power-up is not trusted
    skip_rd = 1;
    xfer(0, 8'h62, 0, 0, 0);
    skip_rd = 0;
    xfer(0, 8'h50, 0, 0, 1);
    xfer(1, 8'h60, 8'hff, 0, 1);
    xfer(1, 8'h3f, 8'hff, 0, 0);
    xfer(0, 8'h3f, 0, 8'h7f, 0);
    xfer(1, 8'h3f, 0, 0, 0);
    pri = 6'h3f;
    sec = 6'h2a;
    @(negedge ref_clk);
    {pri, sec} = 0;
    xfer(0, 8'h61, 0, 8'h2a, 0);
    xfer(0, 8'h60, 0, 0, 0);
    mr_n = 0;
    repeat (2) @(negedge ref_clk);
    mr_n = 1;
    xfer(0, 8'h62, 0, 8'h40, 0);
    // Watchdog one kicked by the processor on input one only
    run = 1;
    xfer(1, 8'h3c, 8'h40, 0, 0);
    xfer(1, 8'h3d, 8'h40, 0, 0);
    repeat (60) @(negedge ref_clk);
    chk("wd_fault", 0, {7'h0, wd_f[0]});
    run = 0;
    wfault(0);
    xfer(1, 8'h3d, 0, 0, 0);
    xfer(0, 8'h62, 0, 8'h05, 0);
    // Watchdog two cleared by output eight only; input edges ignored
    run = 1;
    xfer(1, 8'h3e, 8'h3c, 0, 0);
    xfer(1, 8'h3f, 8'h40, 0, 0);
    tog_po(7);
    chk("wd_fault", 0, {7'h0, wd_f[1]});
    wfault(1);
    xfer(1, 8'h3f, 0, 0, 0);
    xfer(0, 8'h62, 0, 8'h02, 0);
    // Initial code 1 is four base periods, pulse one cycle after expiry
    xfer(1, 8'h3e, 8'hc1, 0, 0);
    xfer(1, 8'h3f, 8'h48, 0, 0);
    wtime(1, 33);
    wtime(1, 8);
    mr_n = 0;
    @(negedge ref_clk);
    mr_n = 1;
    wtime(1, 32);
    xfer(1, 8'h3f, 0, 0, 0);
    xfer(0, 8'h62, 0, 8'h4a, 0);
    // Both sources needed, input kicks alone do not clear
    xfer(1, 8'h3c, 8'h00, 0, 0);
    xfer(1, 8'h3d, 8'h40, 0, 0);
    wfault(0);
    // Code 11 also needs both; toggling both keeps it quiet
    xfer(1, 8'h3c, 8'h60, 0, 0);
    tog_po(0);
    chk("wd_fault", 0, {7'h0, wd_f[0]});
    end_sim;
  end
endmodule
